// File: logic/motor_lock_defines.svh
// Offsets, field positions, reset values and timing counts for the lock fault block
// Functional notes
// - Retry delay field bits 10-7, 100ms to 14s
// - Codes 0-3 latch fault, set gate state
// - Codes 4-7 auto retry, latch past limit
// - Code 8 reports lock, no gate action
// - Codes 9-F disable motor lock detection
// - Bit 2 enables position detect timeout fault
// - Bit 1 enables position detect frequency fault
// - Bit 0 enables loop saturation indication
// - Second word at 92h, resets to zero
`ifndef MOTOR_LOCK_DEFINES_SVH
`define MOTOR_LOCK_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_FAULT_ONE 10'h091
`define IDX_FAULT_TWO 10'h092
`define IDX_STATUS 10'h0a0
`define IDX_MASK 10'h0a1
`define ADDR_W 12

`define FAULT_ONE_RESET 32'h00000000
`define FAULT_TWO_RESET 32'h00000000

// First fault word fields
`define F1_DELAY_HI 10
`define F1_DELAY_LO 7
`define F1_RESP_HI 6
`define F1_RESP_LO 3
`define F1_IPD_TIMEOUT_EN 2
`define F1_IPD_FREQ_EN 1
`define F1_SAT_EN 0

// Second fault word fields
`define F2_PARITY 31
`define F2_LOCK_EN_HI 30
`define F2_LOCK_EN_LO 28
`define F2_LIMIT_HI 2
`define F2_LIMIT_LO 0

// Response codes
`define RESP_LATCH_MAX 4'h3
`define RESP_RETRY_MAX 4'h7
`define RESP_REPORT 4'h8

// Status and mask bits
`define ST_LOCK 0
`define ST_LATCHED 1
`define ST_IPD_TIMEOUT 2
`define ST_IPD_FREQ 3
`define ST_SAT 4
`define ST_W 5

// Retry delay in ms: code 0, code 1, then steps
`define RETRY_MS_C0 32'h00000064
`define RETRY_MS_C1 32'h000001f4
`define RETRY_MS_STEP 32'h000003e8
`define CLK_HZ 20000000
`define TICK_MS_CYCLES (`CLK_HZ / 1000)

`endif

// File: logic/motor_lock_pkg.sv
// Types shared by the lock fault block and its bench
package motor_lock_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RETRY = 2'b01,
    ST_LATCHED = 2'b10,
    ST_REPORT = 2'b11
  } lock_state_t;

  typedef enum logic [1:0] {
    GATE_TRISTATE = 2'b00,
    GATE_RECIRC = 2'b01,
    GATE_HS_BRAKE = 2'b10,
    GATE_LS_BRAKE = 2'b11
  } gate_mode_t;

  typedef struct packed {
    logic active;
    gate_mode_t mode;
  } gate_cmd_t;

endpackage : motor_lock_pkg

// File: logic/motor_lock_fault_response.sv
// Motor-lock fault response with APB register file and interrupt
`timescale 1ns/10ps
`include "motor_lock_defines.svh"

module motor_lock_fault_response #(
  parameter int unsigned TICK_CYCLES = `TICK_MS_CYCLES // Clock cycles per ms
) (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Sync reset, high
  input wire logic cen, // Clock enable
  input wire motor_lock_pkg::apb_req_t apb_req, // APB request
  output motor_lock_pkg::apb_rsp_t apb_rsp, // APB response
  input wire logic [2:0] lock_detect, // Speed, backemf, missing motor hits
  input wire logic ipd_timeout, // Position detect timeout event
  input wire logic ipd_freq_err, // Position detect frequency event
  input wire logic current_loop_sat, // Current loop saturated
  input wire logic speed_loop_sat, // Speed loop saturated
  output logic fault_output_n, // Fault pin, low active
  output motor_lock_pkg::gate_cmd_t gate_cmd, // Gate driver override
  output logic [1:0] saturation_flags, // {speed, current} saturation
  output logic irq // Level interrupt
);
  import motor_lock_pkg::*;

  logic [31:0] fault_settings_one_reg;
  logic [31:0] fault_settings_one_next;
  logic [31:0] fault_settings_two_reg;
  logic [31:0] fault_settings_two_next;
  logic [`ST_W-1:0] status_reg;
  logic [`ST_W-1:0] status_next;
  logic [`ST_W-1:0] mask_reg;
  logic [`ST_W-1:0] mask_next;
  apb_rsp_t rsp_reg;
  apb_rsp_t rsp_next;
  lock_state_t state_reg;
  lock_state_t state_next;
  logic [2:0] retry_cnt_reg;
  logic [2:0] retry_cnt_next;
  logic [31:0] timer_reg;
  logic [31:0] timer_next;
  gate_cmd_t gate_reg;
  gate_cmd_t gate_next;
  logic fault_n_reg;
  logic fault_n_next;
  logic [1:0] sat_reg;
  logic [1:0] sat_next;
  logic irq_reg;
  logic irq_next;

  logic [9:0] idx;
  logic miss;
  logic [31:0] rd_data;
  logic commit;
  logic wr_one;
  logic wr_two;
  logic wr_status;
  logic wr_mask;
  logic [`ST_W-1:0] clr_vec;
  logic [`ST_W-1:0] set_vec;
  logic [3:0] resp;
  logic [2:0] limit;
  logic lock_hit;
  logic lock_evt;
  logic latch_evt;
  logic fault_clear;
  logic [31:0] retry_cycles;

  // Response class of the lock code, exactly one set
  logic resp_latch;
  logic resp_retry;
  logic resp_report;
  logic resp_off;
  logic retry_done;

  // Retry delay in ms for a delay code
  function automatic logic [31:0] retry_ms(input logic [3:0] code);
    logic [31:0] ms;
    ms = `RETRY_MS_STEP;
    case (code)
      4'h0: ms = `RETRY_MS_C0;
      4'h1: ms = `RETRY_MS_C1;
      default: ms = {28'h0000000, code - 4'h1} * `RETRY_MS_STEP;
    endcase
    return ms;
  endfunction : retry_ms

  // Bus decode; response is registered, so access takes one wait state
  always_comb begin
    idx = apb_req.paddr[`ADDR_W-1:2];
    miss = 1'b0;
    rd_data = 32'h00000000;
    case (idx)
      `IDX_FAULT_ONE: rd_data = fault_settings_one_reg;
      `IDX_FAULT_TWO: rd_data = fault_settings_two_reg;
      `IDX_STATUS: rd_data = {{(32-`ST_W){1'b0}}, status_reg};
      `IDX_MASK: rd_data = {{(32-`ST_W){1'b0}}, mask_reg};
      default: miss = 1'b1;
    endcase
    if (apb_req.paddr[1:0] != 2'b00) begin
      miss = 1'b1;
    end
    rsp_next = '0;
    if (apb_req.psel && apb_req.penable && !rsp_reg.pready) begin
      rsp_next.pready = 1'b1;
      rsp_next.pslverr = miss;
      rsp_next.prdata = (miss || apb_req.pwrite) ? 32'h00000000 : rd_data;
    end
    // Writes land at the edge that completes the transfer
    commit = apb_req.psel && apb_req.penable && rsp_reg.pready && apb_req.pwrite && !miss;
    wr_one = commit && (idx == `IDX_FAULT_ONE);
    wr_two = commit && (idx == `IDX_FAULT_TWO);
    wr_status = commit && (idx == `IDX_STATUS);
    wr_mask = commit && (idx == `IDX_MASK);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsp_reg <= '0;
    end else if (cen) begin
      rsp_reg <= rsp_next;
    end
  end

  // Configuration words
  always_comb begin
    fault_settings_one_next = fault_settings_one_reg;
    fault_settings_two_next = fault_settings_two_reg;
    mask_next = mask_reg;
    if (wr_one) begin
      fault_settings_one_next = apb_req.pwdata;
    end
    if (wr_two) begin
      fault_settings_two_next = apb_req.pwdata;
    end
    if (wr_mask) begin
      mask_next = apb_req.pwdata[`ST_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fault_settings_one_reg <= `FAULT_ONE_RESET;
      fault_settings_two_reg <= `FAULT_TWO_RESET;
      mask_reg <= '0;
    end else if (cen) begin
      fault_settings_one_reg <= fault_settings_one_next;
      fault_settings_two_reg <= fault_settings_two_next;
      mask_reg <= mask_next;
    end
  end

  // Field decode shared by the state machine
  always_comb begin
    resp = fault_settings_one_reg[`F1_RESP_HI:`F1_RESP_LO];
    // Limit is the number of automatic retries before latching
    limit = fault_settings_two_reg[`F2_LIMIT_HI:`F2_LIMIT_LO];
    lock_hit = |(lock_detect & fault_settings_two_reg[`F2_LOCK_EN_HI:`F2_LOCK_EN_LO]);
    fault_clear = wr_status && apb_req.pwdata[`ST_LATCHED];
    retry_cycles = 32'(retry_ms(fault_settings_one_reg[`F1_DELAY_HI:`F1_DELAY_LO]) * TICK_CYCLES);
    retry_done = (timer_reg == 32'h0);
    resp_latch = 1'b0;
    resp_retry = 1'b0;
    resp_report = 1'b0;
    resp_off = 1'b0;
    if (resp <= `RESP_LATCH_MAX) begin
      resp_latch = 1'b1;
    end else if (resp <= `RESP_RETRY_MAX) begin
      resp_retry = 1'b1;
    end else if (resp == `RESP_REPORT) begin
      resp_report = 1'b1;
    end else begin
      // Every code above report turns detection off
      resp_off = 1'b1;
    end
  end

  // Lock response state machine
  always_comb begin
    state_next = state_reg;
    retry_cnt_next = retry_cnt_reg;
    timer_next = timer_reg;
    gate_next = gate_reg;
    lock_evt = 1'b0;
    latch_evt = 1'b0;
    if (resp_off) begin
      // Detection off: drop any pending lock action
      state_next = ST_IDLE;
      gate_next = '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // Hits outside idle are ignored
          if (lock_hit) begin
            lock_evt = 1'b1;
            if (resp_latch) begin
              state_next = ST_LATCHED;
              latch_evt = 1'b1;
              gate_next.active = 1'b1;
              gate_next.mode = gate_mode_t'(resp[1:0]);
            end else if (resp_retry) begin
              gate_next.active = 1'b1;
              gate_next.mode = gate_mode_t'(resp[1:0]);
              if (retry_cnt_reg >= limit) begin
                state_next = ST_LATCHED;
                latch_evt = 1'b1;
              end else begin
                state_next = ST_RETRY;
                retry_cnt_next = retry_cnt_reg + 3'h1;
                timer_next = (retry_cycles == 32'h0) ? 32'h0 : retry_cycles - 32'h1;
              end
            end else if (resp_report) begin
              state_next = ST_REPORT;
              gate_next = '0;
            end
          end
        end
        ST_RETRY: begin
          // Gate stays overridden for the whole delay
          if (retry_done) begin
            state_next = ST_IDLE;
            gate_next = '0;
          end else begin
            timer_next = timer_reg - 32'h1;
          end
        end
        ST_LATCHED, ST_REPORT: begin
          // Clearing also restarts the retry budget
          if (fault_clear) begin
            state_next = ST_IDLE;
            gate_next = '0;
            retry_cnt_next = 3'h0;
          end
        end
        default: begin
          state_next = ST_IDLE;
          gate_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      retry_cnt_reg <= 3'h0;
      timer_reg <= 32'h0;
      gate_reg <= '0;
    end else if (cen) begin
      state_reg <= state_next;
      retry_cnt_reg <= retry_cnt_next;
      timer_reg <= timer_next;
      gate_reg <= gate_next;
    end
  end

  // Sticky status; a set in the clearing cycle survives
  always_comb begin
    set_vec = '0;
    set_vec[`ST_LOCK] = lock_evt;
    set_vec[`ST_LATCHED] = latch_evt;
    set_vec[`ST_IPD_TIMEOUT] = ipd_timeout && fault_settings_one_reg[`F1_IPD_TIMEOUT_EN];
    set_vec[`ST_IPD_FREQ] = ipd_freq_err && fault_settings_one_reg[`F1_IPD_FREQ_EN];
    set_vec[`ST_SAT] = (current_loop_sat || speed_loop_sat) && fault_settings_one_reg[`F1_SAT_EN];
    clr_vec = wr_status ? apb_req.pwdata[`ST_W-1:0] : '0;
    status_next = (status_reg & ~clr_vec) | set_vec;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status_reg <= '0;
    end else if (cen) begin
      status_reg <= status_next;
    end
  end

  // Output flops, fed from next values so pins track state without lag
  always_comb begin
    fault_n_next = !((state_next != ST_IDLE)
                     || status_next[`ST_IPD_TIMEOUT]
                     || status_next[`ST_IPD_FREQ]);
    sat_next = fault_settings_one_reg[`F1_SAT_EN] ? {speed_loop_sat, current_loop_sat} : 2'b00;
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fault_n_reg <= 1'b1;
      sat_reg <= 2'b00;
      irq_reg <= 1'b0;
    end else if (cen) begin
      fault_n_reg <= fault_n_next;
      sat_reg <= sat_next;
      irq_reg <= irq_next;
    end
  end

  assign apb_rsp = rsp_reg;
  assign fault_output_n = fault_n_reg;
  assign gate_cmd = gate_reg;
  assign saturation_flags = sat_reg;
  assign irq = irq_reg;

endmodule : motor_lock_fault_response

// File: test/lock_props_properties.sv
// Port-level assertions for the motor-lock fault response block
`timescale 1ns/10ps
module lock_props #(
  parameter int unsigned TICK_CYCLES = 2 // Cycles per ms
) (
  input wire logic clk_sys, // Clock
  input wire logic srst, // Reset
  input wire logic cen, // Clock enable
  input wire motor_lock_pkg::apb_req_t apb_req, // Request
  input wire motor_lock_pkg::apb_rsp_t apb_rsp, // Response
  input wire logic [2:0] lock_detect, // Lock hits
  input wire logic ipd_timeout, // Timeout event
  input wire logic ipd_freq_err, // Frequency event
  input wire logic current_loop_sat, // Current loop
  input wire logic speed_loop_sat, // Speed loop
  input wire logic fault_output_n, // Fault pin
  input wire motor_lock_pkg::gate_cmd_t gate_cmd, // Gate override
  input wire logic [1:0] saturation_flags // Saturation
);
  import motor_lock_pkg::*;
  // Pin is fed from next status, so a cause is one deep; causes are still looked for two deep
  wire any_ev = |lock_detect || ipd_timeout || ipd_freq_err;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_pready_one: assert property (apb_rsp.pready && cen |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  a_pready_wait: assert property (apb_req.psel && apb_req.penable && !apb_rsp.pready && cen |=> apb_rsp.pready)
    else $error("pready not after one wait state");
  a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  a_sat_follows: assert property ($past(cen) |-> (saturation_flags & ~$past({speed_loop_sat, current_loop_sat})) == 2'b00)
    else $error("saturation flag without cause");
  a_gate_fault: assert property (gate_cmd.active |-> !fault_output_n)
    else $error("gate override without fault");
  a_fault_cause: assert property ($fell(fault_output_n) |-> $past(any_ev) || $past(any_ev, 2))
    else $error("fault without event");
  a_gate_cause: assert property ($rose(gate_cmd.active) |-> $past(|lock_detect) || $past(|lock_detect, 2))
    else $error("gate override without lock");
  a_gate_hold: assert property ($rose(gate_cmd.active) && !apb_req.psel |-> gate_cmd.active[*4])
    else $error("gate override released early");
endmodule : lock_props
bind motor_lock_fault_response lock_props #(.TICK_CYCLES(TICK_CYCLES)) lock_props_inst (
  .clk_sys, .srst, .cen, .apb_req, .apb_rsp, .lock_detect, .ipd_timeout, .ipd_freq_err,
  .current_loop_sat, .speed_loop_sat, .fault_output_n, .gate_cmd, .saturation_flags);

// File: test/apb_host.sv
// APB host model that configures the block through its registers
`timescale 1ns/10ps
module apb_host (
  input wire logic clk_sys, // Clock
  output motor_lock_pkg::apb_req_t apb_req, // Request
  input wire motor_lock_pkg::apb_rsp_t apb_rsp // Response
);
  import motor_lock_pkg::*;
  initial apb_req = '0;
  // Entered just after a rising edge; request held until pready is sampled
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    // Ends on pready; only the bench timeout ends a wait that never sees it
    do begin
      @(posedge clk_sys);
    end while (apb_rsp.pready !== 1'b1);
    rdata = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    // Lets registered outputs catch up with the write
    repeat (2) @(posedge clk_sys);
  endtask : xfer
endmodule : apb_host

// File: test/tb.sv
// Self-checking bench for the motor-lock fault response block
`timescale 1ns/10ps
module tb;
  import motor_lock_pkg::*;
  localparam int TICK = 2;
  localparam logic [11:0] ONE = 12'h244, TWO = 12'h248, STAT = 12'h280;
  localparam int DC[3] = '{0, 1, 3};
  localparam int DMS[3] = '{100, 500, 2000};
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic cen = 1'b1;
  logic [2:0] lock_detect = 3'h0;
  logic ipd_timeout = 1'b0, ipd_freq_err = 1'b0, current_loop_sat = 1'b0, speed_loop_sat = 1'b0;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  gate_cmd_t gate_cmd;
  logic fault_output_n, irq, err;
  logic [1:0] saturation_flags;
  logic [31:0] rd;
  int miscompares = 0, num_checks = 0, cycles = 0;
  motor_lock_fault_response #(.TICK_CYCLES(TICK)) motor_lock_fault_response_inst (.clk_sys(clk_sys),
    .srst(srst), .cen(cen), .apb_req(apb_req), .apb_rsp(apb_rsp), .lock_detect(lock_detect),
    .ipd_timeout(ipd_timeout), .ipd_freq_err(ipd_freq_err), .current_loop_sat(current_loop_sat),
    .speed_loop_sat(speed_loop_sat), .fault_output_n(fault_output_n), .gate_cmd(gate_cmd),
    .saturation_flags(saturation_flags), .irq(irq));
  apb_host apb_host_inst (.clk_sys(clk_sys), .apb_req(apb_req), .apb_rsp(apb_rsp));
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic finish_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb_host_inst.xfer(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb_host_inst.xfer(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask : rdchk
  // Waits well within the shortest retry hold so the override can be seen still held
  task automatic hit(input logic [2:0] b);
    lock_detect <= b;
    @(posedge clk_sys);
    lock_detect <= 3'h0;
    repeat (10) @(posedge clk_sys);
  endtask : hit
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    rdchk(TWO, 32'h0);
    rdchk(ONE, 32'h0);
    hit(3'h7);
    chk(fault_output_n, 1'b1);
    wr(TWO, 32'hf0000007);
    rdchk(TWO, 32'hf0000007);
    apb_host_inst.xfer(1'b0, 12'h300, 32'h0, rd, err);
    chk(err, 1'b1);
    wr(12'h284, 32'h1f);
    for (int m = 0; m < 4; m++) begin
      wr(ONE, m << 3);
      hit(3'h1 << (m % 3));
      chk({gate_cmd, fault_output_n, irq}, {1'b1, m[1:0], 2'b01});
      wr(STAT, 32'h1f);
      chk({gate_cmd, fault_output_n}, 4'h1);
    end
    for (int i = 0; i < 3; i++) begin
      wr(ONE, (DC[i] << 7) | ((4 + i) << 3));
      hit(3'h2);
      chk({gate_cmd, fault_output_n}, {1'b1, i[1:0], 1'b0});
      repeat (DMS[i] * TICK - 30) @(posedge clk_sys);
      chk(fault_output_n, 1'b0);
      repeat (40) @(posedge clk_sys);
      chk({gate_cmd.active, fault_output_n}, 2'b01);
    end
    wr(STAT, 32'h1f);
    wr(TWO, 32'hf0000000);
    wr(ONE, 32'h38);
    hit(3'h4);
    repeat (250) @(posedge clk_sys);
    chk({gate_cmd, fault_output_n}, 4'he);
    rdchk(STAT, 32'h3);
    wr(STAT, 32'h1f);
    wr(ONE, 32'h40);
    hit(3'h1);
    chk({gate_cmd, fault_output_n}, 4'h0);
    wr(STAT, 32'h1f);
    chk(fault_output_n, 1'b1);
    for (int c = 9; c < 17; c += 6) begin
      wr(ONE, c << 3);
      hit(3'h7);
      chk({gate_cmd, fault_output_n}, 4'h1);
    end
    for (int k = 0; k < 4; k++) begin
      wr(ONE, 32'h48 | (k[0] << (k[1] ? 1 : 2)));
      ipd_timeout <= !k[1];
      ipd_freq_err <= k[1];
      @(posedge clk_sys);
      ipd_timeout <= 1'b0;
      ipd_freq_err <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({fault_output_n, irq}, {!k[0], k[0]});
      wr(STAT, 32'h1f);
    end
    for (int k = 0; k < 2; k++) begin
      wr(ONE, 32'h48 | k);
      current_loop_sat <= 1'b1;
      speed_loop_sat <= k[0];
      repeat (3) @(posedge clk_sys);
      chk(saturation_flags, {k[0], k[0]});
      current_loop_sat <= 1'b0;
      speed_loop_sat <= 1'b0;
    end
    // Retry delay must not advance while the clock enable is low
    wr(TWO, 32'hf0000001);
    wr(ONE, 32'h20);
    hit(3'h1);
    cen <= 1'b0;
    repeat (300) @(posedge clk_sys);
    chk({gate_cmd, fault_output_n}, 4'h8);
    cen <= 1'b1;
    repeat (150) @(posedge clk_sys);
    chk(fault_output_n, 1'b0);
    repeat (60) @(posedge clk_sys);
    chk({gate_cmd.active, fault_output_n}, 2'b01);
    wr(ONE, 32'h0);
    wr(TWO, 32'h40000000);
    hit(3'h4);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({gate_cmd, fault_output_n}, 4'h1);
    rdchk(TWO, 32'h0);
    finish_test();
  end
endmodule : tb
